/* rtl/ofs_output_selector.sv */
`timescale 1ns/1ns
// ==========================================================
// Output function selector
//
// Six programmable output terminals of the drive. Each terminal owns
// an option code register; the code picks one internal condition,
// and that condition is sampled into the terminal flop every clock.
//
// Option codes handled here:
//   26      overload notice, second threshold
//   27..29  voltage, current and auxiliary analog input lost
//   31      second-stage PID contribution requested
//   32      network watchdog expired
//   33..38  Boolean operation results one to six
//   39      capacitor bank life warning
//   40      cooling fan enabled but slow
//   41      forward or backward run command present
//   42      heat sink above overheat threshold
//   43      output current below low threshold
//   44..49  sequence program general outputs one to six
//   50      drive ready for commands
//   51, 52  forward, reverse rotation
//   53      major failure trip
//   54, 55  voltage, current input inside window
// Every other code, including the reset value, holds the terminal low.
//
// Register port, byte addresses:
//   0x00..0x14  option code of terminal 0..5, one word apart
//   0x18        status, sticky rising edges of the terminals, read only
//   0x1C        clear, write ones to drop status bits, reads zero
//   0x20        interrupt enable, same layout as status
//   0x24        live terminal levels, read only
//
// Read data stand for exactly one cycle after the read strobe and are
// zero otherwise, so the master may OR several slaves together.
//
// Hazards worth knowing:
//   A terminal follows its condition one clock late; conditions are
//   expected to be synchronous to the system clock already.
//   Writing a new code takes effect on the terminal one clock after
//   the write edge, and the change of level may itself raise status.
//   A rising edge in the same cycle as a clear keeps the status bit,
//   so no event is ever lost to a racing clear.
module ofs_output_selector
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rstn,
    // Register port
    input wire ofs_pkg::ofs_req_s i_req,
    output logic [31:0] o_rdata,
    // Conditions from the drive
    input wire ofs_pkg::ofs_cond_s i_cond,
    // Output terminals and interrupt
    output logic [5:0] o_term,
    output logic o_irq
);

    // ==========================================================
    // Condition selection
    // Maps one option code onto its condition; unknown codes give 0
    function automatic logic ofs_select(
        input logic [7:0] code,
        input ofs_pkg::ofs_cond_s c
    );
        logic r;
        // Default keeps the terminal inactive
        r = 1'b0;
        if (code == ofs_pkg::OFS_C_OVL2)
        begin
            // Current above the second overload notice level
            r = c.overload_notice_two;
        end
        else if (code == ofs_pkg::OFS_C_VLOST)
        begin
            // Voltage input below its disconnect level
            r = c.voltage_input_lost;
        end
        else if (code == ofs_pkg::OFS_C_ILOST)
        begin
            // Current input below its disconnect level
            r = c.current_input_lost;
        end
        else if (code == ofs_pkg::OFS_C_ALOST)
        begin
            // Auxiliary analog input below its disconnect level
            r = c.aux_analog_input_lost;
        end
        else if (code == ofs_pkg::OFS_C_PID2)
        begin
            // First stage saturated, second stage must help
            r = c.pid_second_stage_request;
        end
        else if (code == ofs_pkg::OFS_C_WDOG)
        begin
            // Network watchdog period has run out
            r = c.network_watchdog_timeout;
        end
        else if (code >= ofs_pkg::OFS_C_BOOL1 &&
                 code <= ofs_pkg::OFS_C_BOOL6)
        begin
            // One of six Boolean operation results
            r = c.boolean_result[3'(code - ofs_pkg::OFS_C_BOOL1)];
        end
        else if (code == ofs_pkg::OFS_C_CAP)
        begin
            // Capacitor bank due for replacement
            r = c.capacitor_life_warning;
        end
        else if (code == ofs_pkg::OFS_C_FAN)
        begin
            // Fan enabled but below normal speed
            r = c.fan_speed_low;
        end
        else if (code == ofs_pkg::OFS_C_RUN)
        begin
            // Either run command keeps the terminal on
            r = c.forward_run_command | c.backward_run_command;
        end
        else if (code == ofs_pkg::OFS_C_HEAT)
        begin
            // Heat sink above its warning level
            r = c.heatsink_overheat;
        end
        else if (code == ofs_pkg::OFS_C_LOWI)
        begin
            // Output current below its low level
            r = c.low_current_flag;
        end
        else if (code >= ofs_pkg::OFS_C_SEQ1 &&
                 code <= ofs_pkg::OFS_C_SEQ6)
        begin
            // Sequence program outputs passed straight through
            r = c.sequence_general_out[3'(code - ofs_pkg::OFS_C_SEQ1)];
        end
        else if (code == ofs_pkg::OFS_C_READY)
        begin
            // Drive accepts run and inching commands
            r = c.drive_ready;
        end
        else if (code == ofs_pkg::OFS_C_FWDROT)
        begin
            // Motor driven forward
            r = c.forward_rotation;
        end
        else if (code == ofs_pkg::OFS_C_BWDROT)
        begin
            // Motor driven in reverse
            r = c.reverse_rotation;
        end
        else if (code == ofs_pkg::OFS_C_MAJOR)
        begin
            // Trip from an internal hardware error
            r = c.major_failure;
        end
        else if (code == ofs_pkg::OFS_C_VWIN)
        begin
            // Voltage input inside its window
            r = c.voltage_window_match;
        end
        else if (code == ofs_pkg::OFS_C_IWIN)
        begin
            // Current input inside its window
            r = c.current_window_match;
        end
        return r;
    endfunction : ofs_select

    // ==========================================================
    // Reset synchroniser
    logic rst_meta_q;
    logic rst_n_q;

    // Asynchronous assert, release through two flops
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            rst_meta_q <= 1'b0;
            rst_n_q <= 1'b0;
        end
        else
        begin
            rst_meta_q <= 1'b1;
            rst_n_q <= rst_meta_q;
        end
    end

    // ==========================================================
    // Terminals
    logic [7:0] code_q [6];
    logic [5:0] term_q;
    logic [5:0] term_prev_q;

    genvar gi;
    generate
        for (gi = 0; gi < ofs_pkg::OFS_TERMS; gi++)
        begin : g_term
            localparam logic [7:0] ADDR =
                ofs_pkg::OFS_CODE_BASE + 8'(gi * 4);

            // Option code register of this terminal
            always_ff @(posedge i_clk or negedge rst_n_q)
            begin
                if (!rst_n_q)
                    code_q[gi] <= ofs_pkg::OFS_CODE_RST;
                else if (i_req.wr && i_req.addr == ADDR)
                    code_q[gi] <= i_req.wdata[7:0];
            end

            // Selected condition sampled every clock
            always_ff @(posedge i_clk or negedge rst_n_q)
            begin
                if (!rst_n_q)
                    term_q[gi] <= 1'b0;
                else
                    term_q[gi] <= ofs_select(code_q[gi], i_cond);
            end
        end
    endgenerate

    // ==========================================================
    // Interrupt status
    logic [5:0] status_q;
    logic [5:0] enable_q;
    logic [5:0] rise;
    logic [5:0] clr;

    assign rise = term_q & ~term_prev_q;
    assign clr = (i_req.wr && i_req.addr == ofs_pkg::OFS_CLEAR) ?
                 i_req.wdata[5:0] : 6'h00;

    // Previous terminal level for edge detection
    always_ff @(posedge i_clk or negedge rst_n_q)
    begin
        if (!rst_n_q)
            term_prev_q <= 6'h00;
        else
            term_prev_q <= term_q;
    end

    // Sticky status; a new rising edge beats a clear
    always_ff @(posedge i_clk or negedge rst_n_q)
    begin
        if (!rst_n_q)
            status_q <= 6'h00;
        else
            status_q <= (status_q & ~clr) | rise;
    end

    // Interrupt enable register
    always_ff @(posedge i_clk or negedge rst_n_q)
    begin
        if (!rst_n_q)
            enable_q <= ofs_pkg::OFS_ENABLE_RST;
        else if (i_req.wr && i_req.addr == ofs_pkg::OFS_ENABLE)
            enable_q <= i_req.wdata[5:0];
    end

    // Level interrupt output
    always_ff @(posedge i_clk or negedge rst_n_q)
    begin
        if (!rst_n_q)
            o_irq <= 1'b0;
        else
            o_irq <= |(status_q & enable_q);
    end

    // ==========================================================
    // Read data, one cycle after the strobe
    // Zero outside a read so that idle data never leak onto the bus;
    // unaligned, unmapped and write-only addresses also read zero
    always_ff @(posedge i_clk or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            o_rdata <= 32'h0000_0000;
        end
        else if (!i_req.rd)
        begin
            o_rdata <= 32'h0000_0000;
        end
        else if (i_req.addr <= ofs_pkg::OFS_CODE_LAST &&
                 i_req.addr[1:0] == 2'b00)
        begin
            // Option code of one terminal
            o_rdata <= {24'h00_0000, code_q[i_req.addr[4:2]]};
        end
        else if (i_req.addr == ofs_pkg::OFS_STATUS)
        begin
            // Sticky edge status
            o_rdata <= {26'h000_0000, status_q};
        end
        else if (i_req.addr == ofs_pkg::OFS_ENABLE)
        begin
            // Interrupt enables
            o_rdata <= {26'h000_0000, enable_q};
        end
        else if (i_req.addr == ofs_pkg::OFS_LIVE)
        begin
            // Present terminal levels
            o_rdata <= {26'h000_0000, term_q};
        end
        else
        begin
            o_rdata <= 32'h0000_0000;
        end
    end

    assign o_term = term_q;

endmodule : ofs_output_selector

/* rtl/ofs_pkg.sv */
// Behaviour
// - Code 26: current above overload threshold two
// - Codes 27-29: voltage, current, aux input lost
// - Code 31: second-stage PID contribution requested
// - Code 32: network watchdog period has expired
// - Codes 33-38: six Boolean operation results
// - Code 39: capacitor bank needs replacement
// - Code 40: fan enabled but running slow
// - Code 41: forward or reverse run command
// - Code 42: heat sink above overheat threshold
// - Code 43: output current below low threshold
// - Codes 44-49: sequence general outputs passed through
// - Code 50: drive ready for commands
// - Codes 51/52: forward, reverse rotation
// - Code 53: trip from internal hardware error
// - Codes 54/55: voltage, current inside window
package ofs_pkg;

    // ==========================================================
    // Sizes
    localparam int OFS_TERMS = 6;
    localparam int OFS_CODE_W = 8;
    localparam int OFS_ADDR_W = 8;
    localparam int OFS_DATA_W = 32;

    // ==========================================================
    // Register map (byte addresses)
    localparam logic [7:0] OFS_CODE_BASE = 8'h00;
    localparam logic [7:0] OFS_CODE_LAST = 8'h14;
    localparam logic [7:0] OFS_STATUS = 8'h18;
    localparam logic [7:0] OFS_CLEAR = 8'h1C;
    localparam logic [7:0] OFS_ENABLE = 8'h20;
    localparam logic [7:0] OFS_LIVE = 8'h24;

    // ==========================================================
    // Reset values
    localparam logic [7:0] OFS_CODE_RST = 8'h00;
    localparam logic [5:0] OFS_ENABLE_RST = 6'h00;

    // ==========================================================
    // Option codes
    localparam logic [7:0] OFS_C_OVL2 = 8'h1A;     // 26
    localparam logic [7:0] OFS_C_VLOST = 8'h1B;    // 27
    localparam logic [7:0] OFS_C_ILOST = 8'h1C;    // 28
    localparam logic [7:0] OFS_C_ALOST = 8'h1D;    // 29
    localparam logic [7:0] OFS_C_PID2 = 8'h1F;     // 31
    localparam logic [7:0] OFS_C_WDOG = 8'h20;     // 32
    localparam logic [7:0] OFS_C_BOOL1 = 8'h21;    // 33
    localparam logic [7:0] OFS_C_BOOL6 = 8'h26;    // 38
    localparam logic [7:0] OFS_C_CAP = 8'h27;      // 39
    localparam logic [7:0] OFS_C_FAN = 8'h28;      // 40
    localparam logic [7:0] OFS_C_RUN = 8'h29;      // 41
    localparam logic [7:0] OFS_C_HEAT = 8'h2A;     // 42
    localparam logic [7:0] OFS_C_LOWI = 8'h2B;     // 43
    localparam logic [7:0] OFS_C_SEQ1 = 8'h2C;     // 44
    localparam logic [7:0] OFS_C_SEQ6 = 8'h31;     // 49
    localparam logic [7:0] OFS_C_READY = 8'h32;    // 50
    localparam logic [7:0] OFS_C_FWDROT = 8'h33;   // 51
    localparam logic [7:0] OFS_C_BWDROT = 8'h34;   // 52
    localparam logic [7:0] OFS_C_MAJOR = 8'h35;    // 53
    localparam logic [7:0] OFS_C_VWIN = 8'h36;     // 54
    localparam logic [7:0] OFS_C_IWIN = 8'h37;     // 55

    // ==========================================================
    // Conditions delivered by the other units
    typedef struct packed {
        logic overload_notice_two;
        logic voltage_input_lost;
        logic current_input_lost;
        logic aux_analog_input_lost;
        logic pid_second_stage_request;
        logic network_watchdog_timeout;
        logic [5:0] boolean_result;
        logic capacitor_life_warning;
        logic fan_speed_low;
        logic forward_run_command;
        logic backward_run_command;
        logic heatsink_overheat;
        logic low_current_flag;
        logic [5:0] sequence_general_out;
        logic drive_ready;
        logic forward_rotation;
        logic reverse_rotation;
        logic major_failure;
        logic voltage_window_match;
        logic current_window_match;
    } ofs_cond_s;

    // Register port request
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } ofs_req_s;

endpackage : ofs_pkg

/* verification/ofs_properties.sv */
`timescale 1ns/1ns
// ===================================
// Output selector properties
module ofs_properties
(
    // Clock, reset, register port
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire ofs_pkg::ofs_req_s i_req,
    input wire logic [31:0] o_rdata,
    // Conditions and outputs
    input wire ofs_pkg::ofs_cond_s i_cond,
    input wire logic [5:0] o_term,
    input wire logic o_irq
);
    logic [7:0] c0_q;
    logic [5:0] en_q;
    logic und;
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rstn);
    // Shadow of terminal 0 code and of the enables
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            c0_q <= 8'h00;
            en_q <= 6'h00;
        end
        else if (i_req.wr && i_req.addr == 8'h00)
            c0_q <= i_req.wdata[7:0];
        else if (i_req.wr && i_req.addr == 8'h20)
            en_q <= i_req.wdata[5:0];
    end
    // Codes with no function
    assign und = c0_q < 8'h1A || c0_q == 8'h1E || c0_q > 8'h37;
    a_reset_quiet:
    assert property (disable iff (1'b0) !i_rstn |-> o_term == 6'h00 && !o_irq)
        else $error("outputs active in reset");
    a_undef_low:
    assert property (und |=> !o_term[0]) else $error("undefined code drives");
    a_run_either:
    assert property (c0_q == 8'h29 |=> o_term[0] ==
        $past(i_cond.forward_run_command | i_cond.backward_run_command))
        else $error("run select wrong");
    a_fwd_rot:
    assert property (c0_q == 8'h33 |=> o_term[0] ==
        $past(i_cond.forward_rotation)) else $error("rotation wrong");
    a_seq_pass:
    assert property (c0_q == 8'h2C |=> o_term[0] ==
        $past(i_cond.sequence_general_out[0])) else $error("seq wrong");
    a_rdata_idle:
    assert property (!i_req.rd |=> o_rdata == 32'h0) else $error("rdata");
    a_live_read:
    assert property (i_req.rd && i_req.addr == 8'h24 |=>
        o_rdata == {26'h0, $past(o_term)}) else $error("live read");
    a_hole_read:
    assert property (i_req.rd && i_req.addr > 8'h24 |=> o_rdata == 32'h0)
        else $error("unmapped read");
    a_irq_raise:
    assert property ($rose(o_term[0]) && en_q[0] |-> ##[1:2] o_irq)
        else $error("irq missing");
    a_irq_masked:
    assert property ((en_q == 6'h00) [*3] |-> !o_irq) else $error("irq");
    cover property (c0_q == 8'h29 ##1 o_term[0]);
    cover property ($rose(o_irq));
    cover property (i_req.rd && i_req.addr == 8'h24);
endmodule : ofs_properties

bind ofs_output_selector ofs_properties i_ofs_properties
(
    .i_clk, .i_rstn, .i_req, .o_rdata, .i_cond, .o_term, .o_irq
);

/* verification/ofs_relay_model.sv */
`timescale 1ns/1ns
// ===================================
// Relay bank reading the terminals
module ofs_relay_model
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rstn,
    // Terminals in, contacts out
    input wire logic [5:0] i_term,
    output logic [5:0] o_closed
);
    // Contacts follow the terminals one clock later
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            o_closed <= 6'h00;
        else
            o_closed <= i_term;
    end
endmodule : ofs_relay_model

/* verification/output_function_selector_test.sv */
`timescale 1ns/1ns
// ===================================
// Output selector testbench
module output_function_selector_test;
    logic clk;
    logic rstn;
    ofs_pkg::ofs_req_s req;
    ofs_pkg::ofs_cond_s cond;
    logic [31:0] rdata;
    logic [5:0] term;
    logic [5:0] closed;
    logic irq;
    int error_cnt;
    int cmp_count;
    ofs_output_selector i_ofs_output_selector
    (
        .i_clk(clk), .i_rstn(rstn), .i_req(req), .o_rdata(rdata),
        .i_cond(cond), .o_term(term), .o_irq(irq)
    );
    ofs_relay_model i_ofs_relay_model
    (
        .i_clk(clk), .i_rstn(rstn), .i_term(term), .o_closed(closed)
    );
    task automatic test_done;
        if (error_cnt == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : test_done
    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        cmp_count++;
        if (g !== e)
        begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic cyc(int n);
        repeat (n) @(posedge clk);
    endtask : cyc
    // One write strobe, then a quiet cycle
    task automatic wr(logic [7:0] a, logic [31:0] d);
        req <= '{a, d, 1'b1, 1'b0};
        @(posedge clk);
        req.wr <= 1'b0;
        @(posedge clk);
    endtask : wr
    // Read strobe, data judged in the following cycle
    task automatic rd(logic [7:0] a, logic [31:0] e, string nm);
        req <= '{a, 32'h0, 1'b0, 1'b1};
        @(posedge clk);
        req.rd <= 1'b0;
        #1 chk(nm, e, rdata);
        @(posedge clk);
    endtask : rd
    // Condition bits that a code selects
    function automatic logic [29:0] msk(int k);
        if (k >= 26 && k <= 29 || k == 42 || k == 43 || k >= 50 && k <= 55)
            return 30'h1 << (55 - k);
        if (k == 31 || k == 32 || k == 39 || k == 40)
            return 30'h1 << (56 - k);
        if (k >= 33 && k <= 38)
            return 30'h1 << (k - 15);
        if (k >= 44 && k <= 49)
            return 30'h1 << (k - 38);
        return k == 41 ? 30'h3 << 14 : 30'h0;
    endfunction : msk
    task automatic t_regs;
        rd(8'h00, 32'h0, "code reset");
        for (int i = 0; i < 6; i++)
            wr(8'(4 * i), 32'h2C + i);
        for (int i = 0; i < 6; i++)
            rd(8'(4 * i), 32'h2C + i, "code");
        wr(8'h18, 32'h3F);
        rd(8'h18, 32'h0, "status ro");
        rd(8'h28, 32'h0, "unmapped");
        cond.sequence_general_out <= 6'h15;
        cyc(3);
        chk("relay", 32'h15, 32'(closed));
        rd(8'h24, 32'h15, "live");
    endtask : t_regs
    task automatic t_sel;
        logic [29:0] v;
        for (int k = 0; k < 58; k++)
        begin
            wr(8'h00, 32'(k));
            for (int b = 0; b < 31; b++)
            begin
                v = b < 30 ? 30'h1 << b : 30'h0;
                cond <= v;
                cyc(2);
                chk("term0", 32'(|(v & msk(k))), 32'(term[0]));
            end
        end
    endtask : t_sel
    task automatic t_irq;
        wr(8'h00, 32'h32);
        wr(8'h1C, 32'h3F);
        wr(8'h20, 32'h01);
        cond.drive_ready <= 1'b1;
        cyc(4);
        chk("irq", 32'h1, 32'(irq));
        cond.drive_ready <= 1'b0;
        cyc(2);
        rd(8'h18, 32'h1, "status");
        wr(8'h20, 32'h00);
        cyc(1);
        chk("masked", 32'h0, 32'(irq));
        wr(8'h20, 32'h01);
        cyc(1);
        chk("unmasked", 32'h1, 32'(irq));
        wr(8'h1C, 32'h01);
        cyc(1);
        chk("cleared", 32'h0, 32'(irq));
        rd(8'h18, 32'h0, "status");
    endtask : t_irq
    // Clock
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // Main sequence
    initial
    begin
        rstn = 1'b0;
        req = '0;
        cond = '0;
        error_cnt = 0;
        cmp_count = 0;
        cyc(2);
        rstn <= 1'b1;
        cyc(3);
        t_regs;
        t_sel;
        t_irq;
        test_done;
    end
    // Watchdog
    initial
    begin
        #400000;
        error_cnt++;
        test_done;
    end
endmodule : output_function_selector_test
